// ---- profile_position_options_monitor.v ----
// Positioning options, relative reference, setpoint release, rotary direction and slippage monitor.
// Operation
// - Relative move reference: previous target, ramp output or actual position by code.
// - Release option chooses master, on-target or immediate clearing of new-setpoint.
// - When the device clears new-setpoint, it also clears setpoint-acknowledge.
// - Code 00 acts linear, wrapping preset at range limits; only it allows long moves.
// - Code 01 moves only negative, through minimum limit when target is above.
// - Code 10 moves only positive, through maximum limit when target is below.
// - Code 11 takes the shortest path, positive when difference is under half turn.
// - Velocity mode sets status bit 13 when speed deviation exceeds slip limit.
// - Slippage flag rises only after deviation persists beyond the slippage time.
// - Slip limit at largest positive value switches slippage monitoring off.
// - With a slippage reaction configured, a slippage error logs an error entry.
// - Present following error is exposed as a signed 32-bit read-only value.
// - Correction speed from position difference by PI terms, exposed read-only.
`timescale 1ns/1ns
`default_nettype none
`include "pp_options_defines.vh"

module profile_position_options_monitor #(
  parameter integer W = 32
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         clk_en,
  // Object access port from the fieldbus side.
  input  wire [15:0]  obj_index,
  input  wire         obj_write,
  input  wire         obj_read,
  input  wire [31:0]  obj_wdata,
  output reg  [31:0]  obj_rdata_q,
  output reg          obj_ack_q,
  output reg          obj_err_q,
  // Controlword and statusword bits.
  input  wire         cw_new_setpoint_set,
  input  wire         cw_relative,
  input  wire         pp_mode,
  input  wire         pv_mode,
  output reg          cw_new_setpoint_q,
  output reg          sw_setpoint_ack_q,
  output reg          sw_slippage_q,
  // Motion quantities.
  input  wire [W-1:0] target_position,
  input  wire [W-1:0] ramp_output,
  input  wire [W-1:0] actual_position,
  input  wire [W-1:0] demand_position,
  input  wire [W-1:0] range_min,
  input  wire [W-1:0] range_max,
  input  wire         target_reached,
  input  wire         setpoint_accepted,
  input  wire [W-1:0] set_speed,
  input  wire [W-1:0] actual_speed,
  input  wire [31:0]  slip_time_cycles,
  input  wire         slip_reaction_enabled,
  input  wire [15:0]  gain_p,
  input  wire [15:0]  gain_i,
  // Move plan handed to the trajectory logic.
  output reg  [W-1:0] abs_target_q,
  output reg  [W-1:0] move_distance_q,
  output reg          move_positive_q,
  output reg          move_wraps_q,
  output reg          move_valid_q,
  output reg          error_log_q,
  output reg  [W-1:0] following_error_q,
  output wire [W-1:0] correction_speed
);

  // Stored option word and slippage limit, the last target for relative moves, the
  // slippage persistence count and the pending automatic release.
  reg  [15:0]  options_q;
  reg  [31:0]  slip_limit_q;
  reg  [W-1:0] prev_target_q;
  reg          have_prev_q;
  reg  [31:0]  slip_cnt_q;
  reg          release_pend_q;

  // Option fields; the reserved reference code behaves like the previous-target code, but release code 11 never clears the acknowledge.
  wire [1:0] rel_code = options_q[`REL_MSB:`REL_LSB];
  wire [1:0] rro_code = options_q[`RRO_MSB:`RRO_LSB];
  wire [1:0] rad_code = options_q[`RAD_MSB:`RAD_LSB];

  // Reference for a relative move; reserved code falls back to the default.
  // With no earlier target the previous-target code refers to zero.
  reg [W-1:0] rel_base;
  always @*
  begin
    case (rel_code)
      `CODE_01: rel_base = ramp_output;
      `CODE_10: rel_base = actual_position;
      default:  rel_base = have_prev_q ? prev_target_q : {W{1'b0}};
    endcase
  end

  // Target of the move and the forward and backward distances on the modulo scale.
  // All positions are two's complement; the span is the width of the position range.
  wire [W-1:0] new_target = cw_relative ? rel_base + target_position : target_position;
  wire [W-1:0] span       = range_max - range_min;
  wire [W-1:0] fwd_dist   = new_target - actual_position;
  wire [W-1:0] fwd_mod    = $signed(new_target) >= $signed(actual_position) ?
                            fwd_dist : fwd_dist + span;
  wire [W-1:0] back_mod   = span - fwd_mod;
  wire         below      = $signed(new_target) < $signed(actual_position);

  // Direction and distance of the move according to the rotary policy.
  // Only the linear policy may plan a move longer than the span.
  reg [W-1:0] dist_d;
  reg         pos_d;
  reg         wrap_d;
  always @*
  begin
    dist_d = fwd_dist;
    pos_d  = !below;
    wrap_d = 1'b0;
    // Each policy overrides the linear defaults set above; a move to the present position
    // never passes a limit and counts as zero distance, except under code 01, which plans the whole span.
    case (rad_code)
      `CODE_01:
      begin
        pos_d  = 1'b0;
        dist_d = back_mod;
        wrap_d = !below && (new_target != actual_position);
      end
      `CODE_10:
      begin
        pos_d  = 1'b1;
        dist_d = fwd_mod;
        wrap_d = below;
      end
      `CODE_11:
      begin
        pos_d  = fwd_mod < {1'b0, span[W-1:1]};
        dist_d = pos_d ? fwd_mod : back_mod;
        wrap_d = pos_d ? below : !below;
      end
      default:
      begin
        pos_d  = !below;
        dist_d = below ? actual_position - new_target : fwd_dist;
        wrap_d = 1'b0;
      end
    endcase
  end

  // Linear axis preset wraps to the opposite end when a range limit is reached.
  // The excess beyond the limit is kept, so a long move lands at the same modulo position.
  wire [W-1:0] wrapped_target =
    ($signed(new_target) >= $signed(range_max)) ? range_min + (new_target - range_max) :
    ($signed(new_target) <= $signed(range_min)) ? range_max - (range_min - new_target) :
    new_target;

  // Slippage deviation and its comparison against the limit.
  // The limit is compared unsigned against the magnitude, so a negative limit acts as a huge one.
  // The flag follows the counter by one cycle and drops one cycle after the excess ends.
  wire [W-1:0] speed_dev = actual_speed - set_speed;
  wire [W-1:0] speed_abs = speed_dev[W-1] ? (~speed_dev + 1'b1) : speed_dev;
  wire         slip_off  = (slip_limit_q == `SLIP_OFF_VALUE);
  wire         slip_over = pv_mode && !slip_off && (speed_abs > slip_limit_q);
  wire         slip_fire = slip_over && (slip_cnt_q > slip_time_cycles);

  // Object writes and reads; unknown indices answer with an error.
  // Every request on an enabled cycle is answered one cycle later; a write wins when both strobes are high.
  // The read-only objects refuse a write, so the master sees the error with the answer.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      options_q    <= `RST_POS_OPTIONS;
      slip_limit_q <= `RST_SLIP_LIMIT;
      obj_rdata_q  <= 32'h00000000;
      obj_ack_q    <= 1'b0;
      obj_err_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      obj_ack_q <= obj_write || obj_read;
      obj_err_q <= 1'b0;
      if (obj_write)
      begin
        case (obj_index)
          `IDX_POS_OPTIONS: options_q    <= obj_wdata[15:0];
          `IDX_SLIP_LIMIT:  slip_limit_q <= obj_wdata;
          default:          obj_err_q    <= 1'b1;
        endcase
      end
      else if (obj_read)
      begin
        case (obj_index)
          `IDX_POS_OPTIONS: obj_rdata_q <= {16'h0000, options_q};
          `IDX_FOLLOW_ERR:  obj_rdata_q <= following_error_q;
          `IDX_SLIP_LIMIT:  obj_rdata_q <= slip_limit_q;
          `IDX_CORR_SPEED:  obj_rdata_q <= correction_speed;
          default:
          begin
            obj_rdata_q <= 32'h00000000;
            obj_err_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  // Move planning and the new-setpoint handshake with automatic release.
  // A new move is taken only while the bit is low here, so the master or the automatic
  // release must drop it before the next setpoint can be accepted.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cw_new_setpoint_q <= 1'b0;
      sw_setpoint_ack_q <= 1'b0;
      release_pend_q    <= 1'b0;
      prev_target_q     <= {W{1'b0}};
      have_prev_q       <= 1'b0;
      abs_target_q      <= {W{1'b0}};
      move_distance_q   <= {W{1'b0}};
      move_positive_q   <= 1'b0;
      move_wraps_q      <= 1'b0;
      move_valid_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      move_valid_q <= 1'b0;
      if (cw_new_setpoint_set && !cw_new_setpoint_q && pp_mode)
      begin
        cw_new_setpoint_q <= 1'b1;
        abs_target_q      <= (rad_code == `CODE_00) ? wrapped_target : new_target;
        prev_target_q     <= new_target;
        have_prev_q       <= 1'b1;
        move_distance_q   <= dist_d;
        move_positive_q   <= pos_d;
        move_wraps_q      <= wrap_d;
        move_valid_q      <= 1'b1;
      end
      else if (!cw_new_setpoint_set && rro_code != `CODE_01 && rro_code != `CODE_10)
      begin
        cw_new_setpoint_q <= 1'b0;
      end
      // The release is tested before a fresh acknowledge: while the accepted input stays
      // high the acknowledge branch would otherwise win on every cycle, and the automatic
      // release, and with it the clearing of the acknowledge, would never take place.
      if (release_pend_q &&
          ((rro_code == `CODE_10) || (rro_code == `CODE_01 && target_reached)))
      begin
        cw_new_setpoint_q <= 1'b0;
        sw_setpoint_ack_q <= 1'b0;
        release_pend_q    <= 1'b0;
      end
      else if (setpoint_accepted && cw_new_setpoint_q)
      begin
        sw_setpoint_ack_q <= 1'b1;
        release_pend_q    <= 1'b1;
      end
      else if (!cw_new_setpoint_q && rro_code == `CODE_00)
      begin
        sw_setpoint_ack_q <= 1'b0;
        release_pend_q    <= 1'b0;
      end
    end
  end

  // Persistence counter, slippage status and error logging.
  // The counter saturates so a long excursion never wraps back below the slippage time.
  // An error entry is logged once, on the cycle the status flag rises.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slip_cnt_q        <= 32'h00000000;
      sw_slippage_q     <= 1'b0;
      error_log_q       <= 1'b0;
      following_error_q <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      if (!slip_over)
        slip_cnt_q <= 32'h00000000;
      else if (slip_cnt_q != 32'hffffffff)
        slip_cnt_q <= slip_cnt_q + 32'h00000001;
      sw_slippage_q     <= slip_fire;
      error_log_q       <= slip_fire && !sw_slippage_q && slip_reaction_enabled;
      following_error_q <= demand_position - actual_position;
    end
  end

  // Position loop correction speed; the loop runs in either profile mode.
  // The integrator is cleared by the submodule whenever both modes are off.
  pi_correction #(
    .W (W)
  ) pi_correction_inst (
    .clk           (clk),
    .reset_n       (reset_n),
    .clk_en        (clk_en),
    .loop_enable   (pp_mode || pv_mode),
    .position_diff (demand_position - actual_position),
    .gain_p        (gain_p),
    .gain_i        (gain_i),
    .correction_q  (correction_speed)
  );

endmodule
`default_nettype wire

// ---- pp_options_defines.vh ----
// Object indices, field positions, reset values, codes, bit numbers and widths of the positioning option block.
`ifndef PP_OPTIONS_DEFINES_VH
`define PP_OPTIONS_DEFINES_VH

`define IDX_POS_OPTIONS      16'h60f2
`define IDX_FOLLOW_ERR       16'h60f4
`define IDX_SLIP_LIMIT       16'h60f8
`define IDX_CORR_SPEED       16'h60fa

`define RST_POS_OPTIONS      16'h0001
`define RST_SLIP_LIMIT       32'h00000190
`define SLIP_OFF_VALUE       32'h7fffffff

`define REL_LSB              0
`define REL_MSB              1
`define RRO_LSB              4
`define RRO_MSB              5
`define RAD_LSB              6
`define RAD_MSB              7

`define CODE_00              2'h0
`define CODE_01              2'h1
`define CODE_10              2'h2
`define CODE_11              2'h3

`define CW_NEW_SETPOINT      4
`define CW_RELATIVE          6
`define SW_SETPOINT_ACK      12
`define SW_SLIPPAGE          13

`define SLIP_TIME_WIDTH      32
`define GAIN_SHIFT           8

`endif

// ---- pi_correction.v ----
// Proportional-integral correction speed computed from the position difference.
`timescale 1ns/1ns
`default_nettype none
`include "pp_options_defines.vh"

module pi_correction #(
  parameter integer W = 32
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         clk_en,
  input  wire         loop_enable,
  input  wire [W-1:0] position_diff,
  input  wire [15:0]  gain_p,
  input  wire [15:0]  gain_i,
  output reg  [W-1:0] correction_q
);

  reg  signed [W+15:0] integ_q;
  wire signed [W+16:0] p_term;
  wire signed [W+16:0] i_sum;
  wire signed [W+16:0] total;

  // Products are scaled back by a fixed shift so the gains act as fixed-point numbers.
  assign p_term = $signed(position_diff) * $signed({1'b0, gain_p});
  assign i_sum  = $signed({integ_q[W+15], integ_q})
                + ($signed(position_diff) * $signed({1'b0, gain_i}));
  assign total  = p_term + $signed({integ_q[W+15], integ_q});

  // The integrator clears while the loop is idle so no windup carries into the next move.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      integ_q      <= {(W+16){1'b0}};
      correction_q <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      if (!loop_enable)
      begin
        integ_q      <= {(W+16){1'b0}};
        correction_q <= {W{1'b0}};
      end
      else
      begin
        integ_q      <= i_sum[W+15:0];
        correction_q <= total[W-1+`GAIN_SHIFT:`GAIN_SHIFT];
      end
    end
  end

endmodule
`default_nettype wire

// ---- ppom_checker.sv ----
// Port assertions for the positioning option block.
`timescale 1ns/1ns
`default_nettype none
module ppom_checker #(
  parameter integer W = 32
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         clk_en,
  input wire logic [15:0]  obj_index,
  input wire logic         obj_write,
  input wire logic         obj_read,
  input wire logic         obj_ack_q,
  input wire logic         obj_err_q,
  input wire logic         cw_new_setpoint_set,
  input wire logic         pp_mode,
  input wire logic         pv_mode,
  input wire logic         cw_new_setpoint_q,
  input wire logic         sw_setpoint_ack_q,
  input wire logic         sw_slippage_q,
  input wire logic         slip_reaction_enabled,
  input wire logic         move_valid_q,
  input wire logic         error_log_q,
  input wire logic [W-1:0] demand_position,
  input wire logic [W-1:0] actual_position,
  input wire logic [W-1:0] following_error_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic         live_q;
  // Request strobe, an index that is refused, and the expected following error.
  wire          req = clk_en && (obj_write || obj_read);
  wire          bad = obj_index != 16'h60f2 && obj_index != 16'h60f8
                      && (obj_write || obj_index != 16'h60f4 && obj_index != 16'h60fa);
  wire [W-1:0]  fe_d = demand_position - actual_position;
  // Marks cycles after the first edge out of reset, so history is valid.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  sequence take_s;
    clk_en && cw_new_setpoint_set && !cw_new_setpoint_q && pp_mode;
  endsequence
  sequence slip_rise_s;
    $rose(sw_slippage_q) && slip_reaction_enabled;
  endsequence
  chk_ack_follows: assert property (req |=> obj_ack_q)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (!req |=> !obj_ack_q)
    else $error("ack without request");
  chk_err_index: assert property (req && bad |=> obj_err_q)
    else $error("refused access not flagged");
  chk_take_setpoint: assert property (take_s |=> move_valid_q && cw_new_setpoint_q)
    else $error("new setpoint not taken");
  chk_valid_cause: assert property (move_valid_q |-> $past(pp_mode))
    else $error("move outside position mode");
  chk_ack_release: assert property ($fell(cw_new_setpoint_q) |-> ##[0:1] !sw_setpoint_ack_q)
    else $error("acknowledge kept after release");
  chk_slip_mode: assert property (!pv_mode |=> !sw_slippage_q)
    else $error("slippage flag outside velocity mode");
  chk_slip_log: assert property (slip_rise_s |-> ##[0:1] error_log_q)
    else $error("slippage error not logged");
  chk_follow_err: assert property (live_q |-> following_error_q == $past(fe_d))
    else $error("following error wrong");
endmodule
bind profile_position_options_monitor ppom_checker #(.W(W)) ppom_checker_inst (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .obj_index(obj_index),
  .obj_write(obj_write), .obj_read(obj_read), .obj_ack_q(obj_ack_q), .obj_err_q(obj_err_q),
  .cw_new_setpoint_set(cw_new_setpoint_set), .pp_mode(pp_mode), .pv_mode(pv_mode),
  .cw_new_setpoint_q(cw_new_setpoint_q), .sw_setpoint_ack_q(sw_setpoint_ack_q),
  .sw_slippage_q(sw_slippage_q), .slip_reaction_enabled(slip_reaction_enabled),
  .move_valid_q(move_valid_q), .error_log_q(error_log_q), .demand_position(demand_position),
  .actual_position(actual_position), .following_error_q(following_error_q)
);
`default_nettype wire

// ---- ppom_master.sv ----
// Fieldbus master model for the new-setpoint handshake.
`timescale 1ns/1ns
`default_nettype none
module ppom_master (
  input  wire logic clk,
  input  wire logic move_valid_q,
  input  wire logic sw_setpoint_ack_q,
  output var logic  cw_new_setpoint_set,
  output var logic  setpoint_accepted
);
  initial
  begin
    cw_new_setpoint_set = 1'b0;
    setpoint_accepted = 1'b0;
  end
  // Raises new setpoint, confirms the move, then drops the bit after the acknowledge.
  task automatic send(output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk) cw_new_setpoint_set <= 1'b1;
    for (n = 0; n < 20 && !ok; n++)
      @(posedge clk) #1 ok = (move_valid_q === 1'b1);
    @(posedge clk) setpoint_accepted <= 1'b1;
    ok = ok && 1'b0;
    for (n = 0; n < 20 && (sw_setpoint_ack_q !== 1'b1); n++)
      @(posedge clk) #1;
    ok = (sw_setpoint_ack_q === 1'b1);
    @(posedge clk);
    cw_new_setpoint_set <= 1'b0;
    setpoint_accepted <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- profile_position_options_monitor_tb.sv ----
// Self-checking bench for the positioning option block.
`timescale 1ns/1ns
`default_nettype none
module profile_position_options_monitor_tb;
  logic        clk = 1'b0, reset_n = 1'b0, obj_write = 1'b0, obj_read = 1'b0;
  logic        cw_relative = 1'b0, pp_mode = 1'b1, pv_mode = 1'b0, target_reached = 1'b0;
  logic        slip_reaction_enabled = 1'b1, clk_en = 1'b1;
  logic [15:0] obj_index = 16'h0, gain_p = 16'h0100, gain_i = 16'h0;
  logic [31:0] obj_wdata = 32'h0, target_position = 32'h0, ramp_output = 32'h0;
  logic [31:0] actual_position = 32'h0, demand_position = 32'h0, range_min = 32'h0;
  logic [31:0] range_max = 32'h168, set_speed = 32'h3e8, actual_speed = 32'h3e8;
  logic [31:0] slip_time_cycles = 32'h5;
  wire  [31:0] obj_rdata_q, abs_target_q, following_error_q, correction_speed, move_distance_q;
  wire         obj_ack_q, obj_err_q, cw_new_setpoint_q, sw_setpoint_ack_q, sw_slippage_q;
  wire         move_positive_q, move_wraps_q, move_valid_q, error_log_q;
  wire         cw_new_setpoint_set, setpoint_accepted;
  int          mismatches = 0, compares = 0;
  profile_position_options_monitor profile_position_options_monitor_inst (
    .clk, .reset_n, .clk_en, .obj_index, .obj_write, .obj_read, .obj_wdata,
    .obj_rdata_q, .obj_ack_q, .obj_err_q, .cw_new_setpoint_set, .cw_relative, .pp_mode,
    .pv_mode, .cw_new_setpoint_q, .sw_setpoint_ack_q, .sw_slippage_q, .target_position,
    .ramp_output, .actual_position, .demand_position, .range_min, .range_max,
    .target_reached, .setpoint_accepted, .set_speed, .actual_speed, .slip_time_cycles,
    .slip_reaction_enabled, .gain_p, .gain_i, .abs_target_q, .move_distance_q,
    .move_positive_q, .move_wraps_q, .move_valid_q, .error_log_q, .following_error_q,
    .correction_speed);
  ppom_master ppom_master_inst (.clk, .move_valid_q, .sw_setpoint_ack_q,
    .cw_new_setpoint_set, .setpoint_accepted);
  // Free-running clock at 125 MHz.
  always #4 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One object access: a one-cycle request, the answer one cycle later.
  task automatic obj(input logic w, input logic [15:0] i, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    obj_write <= w;
    obj_read <= !w;
    obj_index <= i;
    obj_wdata <= d;
    @(posedge clk);
    obj_write <= 1'b0;
    obj_read <= 1'b0;
    #1 check("ack", obj_ack_q, 1'b1);
    q = obj_rdata_q;
    e = obj_err_q;
  endtask
  task automatic sp();
    bit ok;
    ppom_master_inst.send(ok);
    if (!ok)
    begin
      check("handshake", 1'b0, 1'b1);
      test_done();
    end
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    obj(0, 16'h60f2, 0, q, e);
    check("options reset", q, 32'h1);
    @(posedge clk);
    clk_en <= 1'b0;
    obj_write <= 1'b1;
    obj_index <= 16'h60f2;
    obj_wdata <= 32'h5;
    @(posedge clk);
    clk_en <= 1'b1;
    obj_write <= 1'b0;
    #1 check("frozen ack", obj_ack_q, 1'b0);
    obj(0, 16'h60f2, 0, q, e);
    check("frozen options", q, 32'h1);
    obj(0, 16'h60f8, 0, q, e);
    check("slip reset", q, 32'h190);
    obj(1, 16'h60f4, 5, q, e);
    check("ro write", e, 1'b1);
    obj(1, 16'h60fa, 5, q, e);
    check("ro write", e, 1'b1);
    obj(0, 16'h6000, 0, q, e);
    check("unknown index", {q[30:0], e}, 32'h1);
    demand_position <= 32'h32;
    actual_position <= 32'h14;
    repeat (3) @(posedge clk);
    obj(0, 16'h60f4, 0, q, e);
    check("following error", q, 32'h1e);
    check("correction", correction_speed, 32'h1e);
    obj(0, 16'h60fa, 0, q, e);
    check("correction read", q, 32'h1e);
  endtask
  // Relative moves under each reference code, auto release as soon as possible.
  task automatic t_rel();
    logic [31:0] q, prev;
    logic        e;
    int          codes [3] = '{1, 2, 0};
    prev = 0;
    cw_relative <= 1'b1;
    ramp_output <= 32'h64;
    target_position <= 32'h7;
    for (int i = 0; i < 3; i++)
    begin
      obj(1, 16'h60f2, 32'h20 | codes[i], q, e);
      sp();
      check("auto release", cw_new_setpoint_q, 1'b0);
      @(posedge clk) #1 check("ack release", sw_setpoint_ack_q, 1'b0);
      prev = (codes[i] == 1 ? 32'h64 : codes[i] == 2 ? 32'h14 : prev) + 7;
      check("relative target", abs_target_q, prev);
    end
    cw_relative <= 1'b0;
  endtask
  // Absolute moves under each rotary direction policy on a 0..360 scale.
  task automatic t_rot();
    logic [31:0] q;
    logic        e;
    int          t [6][7] = '{'{0, 20, 100, 100, 1, 0, 80}, '{1, 20, 100, 100, 0, 1, 280},
                              '{2, 100, 20, 20, 1, 1, 280}, '{3, 10, 100, 100, 1, 0, 90},
                              '{3, 10, 300, 300, 0, 1, 70}, '{0, 20, 370, 10, 1, 0, 350}};
    for (int i = 0; i < 6; i++)
    begin
      actual_position <= t[i][1];
      target_position <= t[i][2];
      obj(1, 16'h60f2, 32'h20 | (t[i][0] << 6), q, e);
      sp();
      check("target", abs_target_q, t[i][3]);
      check("direction", move_positive_q, t[i][4]);
      check("wrap", move_wraps_q, t[i][5]);
      check("distance", move_distance_q, t[i][6]);
    end
  endtask
  // Integral action on a negative position difference after the loop has been cleared.
  task automatic t_pi();
    @(posedge clk);
    pp_mode <= 1'b0;
    gain_p <= 16'h0;
    gain_i <= 16'h0100;
    demand_position <= 32'h0;
    actual_position <= 32'h4;
    @(posedge clk);
    pp_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("integral", correction_speed, 32'hfffffff8);
    check("negative error", following_error_q, 32'hfffffffc);
  endtask
  // Release on target reached, then release left to the master.
  task automatic t_hold();
    logic [31:0] q;
    logic        e;
    obj(1, 16'h60f2, 32'h10, q, e);
    sp();
    repeat (3) @(posedge clk);
    #1 check("held until target", cw_new_setpoint_q, 1'b1);
    @(posedge clk) target_reached <= 1'b1;
    repeat (3) @(posedge clk);
    target_reached <= 1'b0;
    #1 check("released on target", {cw_new_setpoint_q, sw_setpoint_ack_q}, 2'h0);
    obj(1, 16'h60f2, 32'h0, q, e);
    sp();
    check("master keeps bit", cw_new_setpoint_q, 1'b1);
    repeat (2) @(posedge clk);
    #1 check("master release", cw_new_setpoint_q, 1'b0);
  endtask
  // Slippage above and below the set speed, at the limit, and switched off.
  task automatic t_slip();
    logic [31:0] q;
    logic        e;
    logic [31:0] sp_tab [4] = '{32'h579, 32'h257, 32'h578, 32'h579};
    @(posedge clk);
    pp_mode <= 1'b0;
    pv_mode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        obj(1, 16'h60f8, 32'h7fffffff, q, e);
      @(posedge clk) actual_speed <= sp_tab[i];
      slip_reaction_enabled <= (i != 1);
      repeat (4) @(posedge clk);
      #1 check("slip early", sw_slippage_q, 1'b0);
      for (int n = 0; n < 20 && sw_slippage_q !== 1'b1; n++)
        @(posedge clk) #1;
      check("slip flag", sw_slippage_q, i < 2);
      check("slip log", error_log_q, i == 0);
      @(posedge clk) actual_speed <= 32'h3e8;
      repeat (2) @(posedge clk);
      #1 check("slip cleared", sw_slippage_q, 1'b0);
    end
    obj(0, 16'h60f8, 0, q, e);
    check("slip off value", q, 32'h7fffffff);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_rel();
    t_rot();
    t_hold();
    t_pi();
    t_slip();
    test_done();
  end
endmodule
`default_nettype wire
